// ---- rtl/mmc_pkg.sv ----
// Package for the module management control block: register map,
// field positions, reset values, timing counts, states and carriers.
// Assumes a 50 MHz block clock and a 32-bit classic Wishbone bus.
package mmc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned INIT_MS = 2000;
  localparam int unsigned INIT_CYC = INIT_MS * CYC_PER_MS;
  localparam int unsigned WAKE_MS = 300;
  localparam int unsigned WAKE_CYC = WAKE_MS * CYC_PER_MS;
  localparam int unsigned TMR_W = 32;

  // ==========================================================
  // Register byte addresses
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATE = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_FLAG_CLR = 8'h0C;
  localparam logic [7:0] ADR_MASK = 8'h10;
  localparam logic [7:0] ADR_IRQ_EN = 8'h14;
  localparam logic [7:0] ADR_ACTIVITY = 8'h18;

  // ==========================================================
  // Field positions and widths
  localparam int unsigned FLAG_W = 3;
  localparam int unsigned FLAG_RX_LOSS = 0;
  localparam int unsigned FLAG_TX_FAULT = 1;
  localparam int unsigned FLAG_DATA_READY = 2;
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned ACT_W = 16;
  localparam int unsigned SYNC_W = 5;

  // ==========================================================
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  // ==========================================================
  // Power and initialization states
  typedef enum logic [3:0]
  {
    PWR_INIT = 4'h1,
    PWR_LOW = 4'h2,
    PWR_WAKE = 4'h4,
    PWR_ACTIVE = 4'h8
  } mmc_pwr_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic pset;
    logic override;
    logic attn_los;
    logic lp_transmit_disable;
  } mmc_ctrl_s;

  typedef struct packed {
    logic two_wire_clk;
    logic tx_fault;
    logic rx_signal_lost;
    logic low_power_request;
    logic module_reset_n;
  } mmc_pins_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } mmc_wb_req_s;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic busy;
  } mmc_tmr_s;

  typedef struct packed {
    mmc_pwr_e pwr;
    mmc_ctrl_s ctrl;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] mask;
    logic [FLAG_W-1:0] irq_en;
    logic kick;
    logic data_not_ready;
    logic bus_ready;
    logic scl_prev;
    logic [ACT_W-1:0] activity;
    logic ack;
    logic [31:0] rdat;
    logic attn_n;
    logic irq;
    logic transmit_disable;
  } mmc_core_s;

endpackage : mmc_pkg

// ---- rtl/mmc_sync.sv ----
// Two-stage synchronizer for the module pins.
// Assumes every input is asynchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module mmc_sync #(
  parameter int unsigned WIDTH = mmc_pkg::SYNC_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } mmc_sync_s;

  mmc_sync_s s;
  mmc_sync_s next_s;

  always_comb
  begin
    next_s.meta = async_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign sync_o = s.stable;

endmodule : mmc_sync
`default_nettype wire

// ---- rtl/mmc_timer.sv ----
// Down counter that times initialization and wake-up.
// Assumes start_i is a one-cycle pulse from logic on clk_i.
`timescale 1ns/10ps
`default_nettype none
module mmc_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic [mmc_pkg::TMR_W-1:0] load_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  mmc_pkg::mmc_tmr_s s;
  mmc_pkg::mmc_tmr_s next_s;

  always_comb
  begin
    next_s = s;
    if (start_i)
    begin
      next_s.busy = 1'b1;
      next_s.cnt = (load_i == '0) ? mmc_pkg::TMR_W'(1) : load_i;
    end
    else if (s.busy)
    begin
      next_s.cnt = s.cnt - mmc_pkg::TMR_W'(1);
      if (s.cnt == mmc_pkg::TMR_W'(1))
        next_s.busy = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign busy_o = s.busy;
  // Not gated by start_i: the caller never starts while it consumes done
  assign done_o = s.busy && (s.cnt == mmc_pkg::TMR_W'(1));

endmodule : mmc_timer
`default_nettype wire

// ---- rtl/mmc_ctrl.sv ----
// Management control and status logic of one pluggable module end:
// initialization, bus readiness, latched flags with attention output,
// dual-mode pins, low-power control and software power override.
// Assumes a 50 MHz clock, classic Wishbone access and asynchronous pins.
//
// Behaviour
// - Finish management init within 2000 ms.
// - Attention goes low within 200 ms.
// - Reading flags clears them, releasing attention.
// - Signal loss sets flag and attention quickly.
// - Any flag condition sets flag and attention.
// - Set mask stops that flag's attention.
// - Cleared mask restores that flag's attention.
// - Fully functional within 2 s of power-on.
// - Serial bus ready within 2 s.
// - Clear monitor-pending bit, pull attention low.
// - Fully functional within 2 s after reset rise.
// - Shared input switches role within 100 ms.
// - Low-power request reaches class 1 quickly.
// - Low-power release: functional within 300 ms.
// - Shared output switches role within 100 ms.
// - Software power bits act like low-power request.
`timescale 1ns/10ps
`default_nettype none
module mmc_ctrl #(
  parameter int unsigned INIT_CYCLES = mmc_pkg::INIT_CYC,
  parameter int unsigned WAKE_CYCLES = mmc_pkg::WAKE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire mmc_pkg::mmc_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Module pins
  input wire logic module_reset_n_i,
  input wire logic low_power_request_i,
  input wire logic two_wire_clk_i,
  output logic attention_out_n_o,
  // Internal condition detectors
  input wire logic rx_signal_lost_i,
  input wire logic tx_fault_i,
  // Power and status
  output logic transmit_disable_o,
  output logic power_low_o,
  output logic fully_functional_o,
  output logic management_init_state_o,
  output logic bus_ready_o,
  // Interrupt
  output logic irq_o
);

  // ==========================================================
  // Address match
  function automatic logic hit(
    input logic [mmc_pkg::ADR_W-1:0] adr,
    input logic [mmc_pkg::ADR_W-1:0] off
  );
    hit = (adr == off);
  endfunction : hit

  // ==========================================================
  // Declarations
  mmc_pkg::mmc_core_s s;
  mmc_pkg::mmc_core_s next_s;
  mmc_pkg::mmc_pins_s pins_async;
  mmc_pkg::mmc_pins_s pin;
  logic tmr_start;
  logic [mmc_pkg::TMR_W-1:0] tmr_load;
  logic tmr_done;
  logic lp_req;
  logic scl_rise;
  logic req;
  logic [mmc_pkg::FLAG_W-1:0] flag_set;
  logic [mmc_pkg::FLAG_W-1:0] flag_clr;
  logic data_ready_evt;

  // ==========================================================
  // Pin synchronizers
  always_comb
  begin
    pins_async.module_reset_n = module_reset_n_i;
    pins_async.low_power_request = low_power_request_i;
    pins_async.rx_signal_lost = rx_signal_lost_i;
    pins_async.tx_fault = tx_fault_i;
    pins_async.two_wire_clk = two_wire_clk_i;
  end

  mmc_sync #(
    .WIDTH(mmc_pkg::SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .sync_o(pin)
  );

  // ==========================================================
  // Init and wake timer
  mmc_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tmr_start),
    .load_i(tmr_load),
    .busy_o(),
    .done_o(tmr_done)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    tmr_start = 1'b0;
    tmr_load = mmc_pkg::TMR_W'(INIT_CYCLES);
    data_ready_evt = 1'b0;
    flag_clr = '0;
    req = wb_req_i.cyc && wb_req_i.stb && !s.ack;

    // Low-power request from the shared pin or the software bits
    lp_req = (!s.ctrl.lp_transmit_disable && pin.low_power_request)
      || s.ctrl.override || s.ctrl.pset;

    // Two-wire clock edges counted once the bus is ready
    next_s.scl_prev = pin.two_wire_clk;
    scl_rise = pin.two_wire_clk && !s.scl_prev;
    if (scl_rise && s.bus_ready)
      next_s.activity = s.activity + mmc_pkg::ACT_W'(1);

    // --------------------------------------------------------
    // Power and initialization sequence
    if (!pin.module_reset_n)
    begin
      // Held in init while the reset pin is low
      next_s.pwr = mmc_pkg::PWR_INIT;
      next_s.kick = 1'b1;
      next_s.data_not_ready = 1'b1;
    end
    else if (s.kick)
    begin
      // Reset released or power-on: start the init timer
      next_s.kick = 1'b0;
      tmr_start = 1'b1;
      tmr_load = mmc_pkg::TMR_W'(INIT_CYCLES);
    end
    else
    begin
      case (s.pwr)
        mmc_pkg::PWR_INIT:
        begin
          if (tmr_done)
          begin
            next_s.data_not_ready = 1'b0;
            next_s.bus_ready = 1'b1;
            data_ready_evt = 1'b1;
            if (lp_req)
              next_s.pwr = mmc_pkg::PWR_LOW;
            else
              next_s.pwr = mmc_pkg::PWR_ACTIVE;
          end
        end
        mmc_pkg::PWR_LOW:
        begin
          if (!lp_req)
          begin
            tmr_start = 1'b1;
            tmr_load = mmc_pkg::TMR_W'(WAKE_CYCLES);
            next_s.pwr = mmc_pkg::PWR_WAKE;
          end
        end
        mmc_pkg::PWR_WAKE:
        begin
          if (lp_req)
            next_s.pwr = mmc_pkg::PWR_LOW;
          else if (tmr_done)
            next_s.pwr = mmc_pkg::PWR_ACTIVE;
        end
        mmc_pkg::PWR_ACTIVE:
        begin
          if (lp_req)
            next_s.pwr = mmc_pkg::PWR_LOW;
        end
        default:
        begin
          next_s.pwr = mmc_pkg::PWR_INIT;
          next_s.kick = 1'b1;
        end
      endcase
    end

    // --------------------------------------------------------
    // Wishbone register access
    next_s.ack = req;
    if (req)
    begin
      next_s.rdat = '0;
      if (wb_req_i.we)
      begin
        if (wb_req_i.sel[0])
        begin
          if (hit(wb_req_i.adr, mmc_pkg::ADR_CTRL))
            next_s.ctrl = wb_req_i.dat[mmc_pkg::CTRL_W-1:0];
          else if (hit(wb_req_i.adr, mmc_pkg::ADR_FLAG_CLR))
            flag_clr = wb_req_i.dat[mmc_pkg::FLAG_W-1:0];
          else if (hit(wb_req_i.adr, mmc_pkg::ADR_MASK))
            next_s.mask = wb_req_i.dat[mmc_pkg::FLAG_W-1:0];
          else if (hit(wb_req_i.adr, mmc_pkg::ADR_IRQ_EN))
            next_s.irq_en = wb_req_i.dat[mmc_pkg::FLAG_W-1:0];
        end
      end
      else
      begin
        if (hit(wb_req_i.adr, mmc_pkg::ADR_CTRL))
          next_s.rdat[mmc_pkg::CTRL_W-1:0] = s.ctrl;
        else if (hit(wb_req_i.adr, mmc_pkg::ADR_STATE))
          next_s.rdat[7:0] = {s.pwr, s.kick, s.transmit_disable,
                              s.bus_ready, s.data_not_ready};
        else if (hit(wb_req_i.adr, mmc_pkg::ADR_FLAGS))
        begin
          next_s.rdat[mmc_pkg::FLAG_W-1:0] = s.flags;
          flag_clr = s.flags;
        end
        else if (hit(wb_req_i.adr, mmc_pkg::ADR_MASK))
          next_s.rdat[mmc_pkg::FLAG_W-1:0] = s.mask;
        else if (hit(wb_req_i.adr, mmc_pkg::ADR_IRQ_EN))
          next_s.rdat[mmc_pkg::FLAG_W-1:0] = s.irq_en;
        else if (hit(wb_req_i.adr, mmc_pkg::ADR_ACTIVITY))
          next_s.rdat[mmc_pkg::ACT_W-1:0] = s.activity;
      end
    end

    // --------------------------------------------------------
    // Latched flags: a condition present in the clear cycle wins
    flag_set = '0;
    flag_set[mmc_pkg::FLAG_RX_LOSS] = pin.rx_signal_lost;
    flag_set[mmc_pkg::FLAG_TX_FAULT] = pin.tx_fault;
    flag_set[mmc_pkg::FLAG_DATA_READY] = data_ready_evt;
    if (!pin.module_reset_n)
      next_s.flags = flag_set & ~(mmc_pkg::FLAG_W'(1)
                                  << mmc_pkg::FLAG_DATA_READY);
    else
      next_s.flags = (s.flags & ~flag_clr) | flag_set;

    // --------------------------------------------------------
    // Shared output: attention or signal-loss indication
    if (next_s.ctrl.attn_los)
      next_s.attn_n = !pin.rx_signal_lost;
    else
      next_s.attn_n = ~|(next_s.flags & ~next_s.mask);

    // Shared input in its transmit-disable role
    next_s.transmit_disable = next_s.ctrl.lp_transmit_disable && pin.low_power_request;

    // Level interrupt for the local processor
    next_s.irq = |(next_s.flags & next_s.irq_en);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s.pwr <= mmc_pkg::PWR_INIT;
      s.ctrl <= mmc_pkg::CTRL_RST;
      s.flags <= '0;
      s.mask <= mmc_pkg::MASK_RST;
      s.irq_en <= mmc_pkg::IRQ_EN_RST;
      s.kick <= 1'b1;
      s.data_not_ready <= 1'b1;
      s.bus_ready <= 1'b0;
      s.scl_prev <= 1'b0;
      s.activity <= '0;
      s.ack <= 1'b0;
      s.rdat <= '0;
      s.attn_n <= 1'b1;
      s.irq <= 1'b0;
      s.transmit_disable <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign attention_out_n_o = s.attn_n;
  assign transmit_disable_o = s.transmit_disable;
  assign power_low_o = (s.pwr == mmc_pkg::PWR_LOW);
  assign fully_functional_o = (s.pwr == mmc_pkg::PWR_ACTIVE);
  assign management_init_state_o = (s.pwr == mmc_pkg::PWR_INIT);
  assign bus_ready_o = s.bus_ready;
  assign irq_o = s.irq;

endmodule : mmc_ctrl
`default_nettype wire

// ---- verification/mmc_ctrl_props.sv ----
// Assertion checker for mmc_ctrl, bound to every instance.
// Assumes only the top ports; CTRL and MASK are shadowed from bus writes.
`timescale 1ns/10ps
`default_nettype none
module mmc_ctrl_props #(
  parameter int unsigned INIT_CYCLES = 50,
  parameter int unsigned WAKE_CYCLES = 20
) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mmc_pkg::mmc_wb_req_s wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and status
  input wire logic module_reset_n_i,
  input wire logic low_power_request_i,
  input wire logic two_wire_clk_i,
  input wire logic attention_out_n_o,
  input wire logic rx_signal_lost_i,
  input wire logic tx_fault_i,
  input wire logic transmit_disable_o,
  input wire logic power_low_o,
  input wire logic fully_functional_o,
  input wire logic management_init_state_o,
  input wire logic bus_ready_o,
  input wire logic irq_o
);
  logic [3:0] ctrl;
  logic [2:0] mask;
  logic [31:0] n_init;
  logic [31:0] n_wake;
  logic take;
  logic wr;
  logic lp_req;
  logic wake;
  assign take = wb_req_i.cyc & wb_req_i.stb & !wb_ack_o;
  assign wr = take & wb_req_i.we & wb_req_i.sel[0];
  assign lp_req = (!ctrl[0] & low_power_request_i) | ctrl[2] | ctrl[3];
  assign wake = !power_low_o & !fully_functional_o & !management_init_state_o;
  // ==========================================================
  // Shadow registers and phase counters
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= mmc_pkg::CTRL_RST;
      mask <= mmc_pkg::MASK_RST;
      n_init <= 32'h0;
      n_wake <= 32'h0;
    end
    else
    begin
      if (wr && wb_req_i.adr == mmc_pkg::ADR_CTRL)
        ctrl <= wb_req_i.dat[3:0];
      if (wr && wb_req_i.adr == mmc_pkg::ADR_MASK)
        mask <= wb_req_i.dat[2:0];
      n_init <= (management_init_state_o & module_reset_n_i) ?
        n_init + 32'h1 : 32'h0;
      n_wake <= wake ? n_wake + 32'h1 : 32'h0;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer is not a single pulse");
  property p_ready;
    $fell(management_init_state_o) |-> ##[0:1] bus_ready_o;
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus not ready after init");
  property p_init;
    n_init <= INIT_CYCLES + 6;
  endproperty
  a_init: assert property (p_init)
    else $error("init lasts too long");
  property p_rx;
    (rx_signal_lost_i && !mask[0] && !ctrl[1])[*5] |-> !attention_out_n_o;
  endproperty
  a_rx: assert property (p_rx)
    else $error("signal loss gives no attention");
  property p_tx;
    (tx_fault_i && !mask[1] && !ctrl[1])[*5] |-> !attention_out_n_o;
  endproperty
  a_tx: assert property (p_tx)
    else $error("fault gives no attention");
  property p_mask;
    (!ctrl[1] && mask == 3'h7)[*2] |-> attention_out_n_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked flags still give attention");
  property p_unmask;
    $fell(mask[0]) && rx_signal_lost_i && $past(rx_signal_lost_i, 3)
      && !ctrl[1] |-> ##[0:2] !attention_out_n_o;
  endproperty
  a_unmask: assert property (p_unmask)
    else $error("unmasked flag gives no attention");
  property p_clear;
    (!rx_signal_lost_i && !tx_fault_i && !ctrl[1]
      && !management_init_state_o)[*4] ##0 (take && !wb_req_i.we
      && wb_req_i.adr == mmc_pkg::ADR_FLAGS) |-> ##[1:2] attention_out_n_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("attention kept after flags read");
  property p_los;
    (ctrl[1] && $stable(rx_signal_lost_i))[*4]
      |-> attention_out_n_o == !rx_signal_lost_i;
  endproperty
  a_los: assert property (p_los)
    else $error("output does not show signal loss");
  property p_transmit_disable;
    ($stable(low_power_request_i) && $stable(ctrl[0]))[*4]
      |-> transmit_disable_o == (ctrl[0] & low_power_request_i);
  endproperty
  a_transmit_disable: assert property (p_transmit_disable)
    else $error("shared input has the wrong role");
  property p_lp;
    (lp_req && !wake)[*5] |-> !fully_functional_o;
  endproperty
  a_lp: assert property (p_lp)
    else $error("low power not reached");
  property p_wake;
    n_wake <= WAKE_CYCLES + 3;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake-up lasts too long");
endmodule : mmc_ctrl_props
bind mmc_ctrl mmc_ctrl_props #(.INIT_CYCLES(INIT_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)) mmc_ctrl_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .module_reset_n_i(module_reset_n_i), .tx_fault_i(tx_fault_i),
  .low_power_request_i(low_power_request_i), .irq_o(irq_o),
  .two_wire_clk_i(two_wire_clk_i), .attention_out_n_o(attention_out_n_o),
  .rx_signal_lost_i(rx_signal_lost_i), .power_low_o(power_low_o),
  .transmit_disable_o(transmit_disable_o), .bus_ready_o(bus_ready_o),
  .fully_functional_o(fully_functional_o),
  .management_init_state_o(management_init_state_o));
`default_nettype wire

// ---- verification/mmc_host_model.sv ----
// Host controller model on the module management pins.
// Assumes a 50 MHz clk_i; the serial clock idles high between bursts.
`timescale 1ns/10ps
`default_nettype none
module mmc_host_model (
  // Clock
  input wire logic clk_i,
  // Host pins
  output logic module_reset_n_o,
  output logic low_power_request_o,
  output logic two_wire_clk_o
);
  initial
  begin
    module_reset_n_o = 1'h1;
    low_power_request_o = 1'h0;
    two_wire_clk_o = 1'h1;
  end
  // Reset pulse of 500 cycles, 10 us
  task automatic pulse_reset();
    @(posedge clk_i);
    module_reset_n_o <= 1'h0;
    repeat (500) @(posedge clk_i);
    module_reset_n_o <= 1'h1;
  endtask : pulse_reset
  task automatic set_lp(input logic v);
    @(posedge clk_i);
    low_power_request_o <= v;
  endtask : set_lp
  // 160 ns serial clock: four cycles low, four high, idle high after
  task automatic burst(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      two_wire_clk_o <= 1'h0;
      repeat (4) @(posedge clk_i);
      two_wire_clk_o <= 1'h1;
      repeat (3) @(posedge clk_i);
    end
  endtask : burst
endmodule : mmc_host_model
`default_nettype wire

// ---- verification/tb_mmc_ctrl.sv ----
// Self-checking bench for mmc_ctrl with short init and wake counts.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module tb_mmc_ctrl;
  localparam int unsigned INIT_N = 50;
  localparam int unsigned WAKE_N = 20;
  logic clk_i, rst_i, rx, tx, ack, attn_n, transmit_disable, plow, ffun, init_st;
  logic bready, irq, rstn, lp, scl;
  logic [31:0] dat, q;
  mmc_pkg::mmc_wb_req_s req;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  mmc_ctrl #(.INIT_CYCLES(INIT_N), .WAKE_CYCLES(WAKE_N)) mmc_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .module_reset_n_i(rstn), .low_power_request_i(lp),
    .two_wire_clk_i(scl), .attention_out_n_o(attn_n),
    .rx_signal_lost_i(rx), .tx_fault_i(tx), .transmit_disable_o(transmit_disable),
    .power_low_o(plow), .fully_functional_o(ffun),
    .management_init_state_o(init_st), .bus_ready_o(bready), .irq_o(irq));
  mmc_host_model mmc_host_model_i (.clk_i(clk_i),
    .module_reset_n_o(rstn), .low_power_request_o(lp), .two_wire_clk_o(scl));
  initial
  begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================================
  // Tasks
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{1'h1, 1'h1, we, 4'hF, a, d};
    @(posedge clk_i);
    while (ack !== 1'h1)
      @(posedge clk_i);
    q = dat;
    req <= '0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    check(q, e);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : settle
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ==========================================================
  // Tests
  initial
  begin
    rst_i = 1'h1;
    rx = 1'h0;
    tx = 1'h0;
    req = '0;
    settle(10);
    rst_i <= 1'h0;
    settle(INIT_N + 8);
    check(ffun, 1'h1);
    check(bready, 1'h1);
    check(attn_n, 1'h0);
    rd(mmc_pkg::ADR_FLAGS, 32'h4);
    settle(2);
    check(attn_n, 1'h1);
    rd(mmc_pkg::ADR_FLAGS, 32'h0);
    rd(mmc_pkg::ADR_STATE, 32'h82);
    rd(mmc_pkg::ADR_CTRL, 32'h0);
    rd(mmc_pkg::ADR_MASK, 32'h0);
    rd(mmc_pkg::ADR_IRQ_EN, 32'h0);
    rd(8'h1C, 32'h0);
    $display("init test done");
    rx <= 1'h1;
    settle(6);
    check(attn_n, 1'h0);
    wr(mmc_pkg::ADR_MASK, 32'h7);
    rd(mmc_pkg::ADR_MASK, 32'h7);
    settle(2);
    check(attn_n, 1'h1);
    wr(mmc_pkg::ADR_MASK, 32'h0);
    settle(2);
    check(attn_n, 1'h0);
    rx <= 1'h0;
    settle(6);
    rd(mmc_pkg::ADR_FLAGS, 32'h1);
    settle(2);
    check(attn_n, 1'h1);
    wr(mmc_pkg::ADR_IRQ_EN, 32'h2);
    tx <= 1'h1;
    settle(6);
    tx <= 1'h0;
    check(attn_n, 1'h0);
    check(irq, 1'h1);
    settle(4);
    wr(mmc_pkg::ADR_FLAG_CLR, 32'h2);
    settle(2);
    check(irq, 1'h0);
    check(attn_n, 1'h1);
    $display("flag test done");
    wr(mmc_pkg::ADR_CTRL, 32'h2);
    rx <= 1'h1;
    settle(6);
    check(attn_n, 1'h0);
    rx <= 1'h0;
    settle(6);
    check(attn_n, 1'h1);
    rd(mmc_pkg::ADR_FLAGS, 32'h1);
    wr(mmc_pkg::ADR_CTRL, 32'h1);
    mmc_host_model_i.set_lp(1'h1);
    settle(6);
    check(transmit_disable, 1'h1);
    check(plow, 1'h0);
    wr(mmc_pkg::ADR_CTRL, 32'h0);
    settle(6);
    check(transmit_disable, 1'h0);
    check(plow, 1'h1);
    mmc_host_model_i.set_lp(1'h0);
    settle(WAKE_N + 6);
    check(ffun, 1'h1);
    wr(mmc_pkg::ADR_CTRL, 32'h4);
    settle(4);
    check(plow, 1'h1);
    wr(mmc_pkg::ADR_CTRL, 32'h8);
    wr(mmc_pkg::ADR_CTRL, 32'h0);
    settle(WAKE_N + 6);
    check(ffun, 1'h1);
    $display("mode and power test done");
    mmc_host_model_i.pulse_reset();
    check(init_st, 1'h1);
    settle(INIT_N + 8);
    check(ffun, 1'h1);
    mmc_host_model_i.burst(16);
    settle(4);
    rd(mmc_pkg::ADR_ACTIVITY, 32'h10);
    $display("reset and serial test done");
    stop_test();
  end
endmodule : tb_mmc_ctrl
`default_nettype wire
